// *** rtl/sdc_consts.svh ***
// Constants of the SYSREF delay calibration register bank
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH

// ==========================================================
// Register addresses (byte addresses on the register port)
`define SDC_ADDR_W 12
`define SDC_ADDR_CFG 12'h2b1
`define SDC_ADDR_STAT0 12'h2b2
`define SDC_ADDR_STAT1 12'h2b3
`define SDC_ADDR_STAT2 12'h2b4
`define SDC_ADDR_MAN0 12'h2b5
`define SDC_ADDR_MAN1 12'h2b6
`define SDC_ADDR_MAN2 12'h2b7

// ==========================================================
// Reset values and field positions
`define SDC_CFG_RST 4'h5
`define SDC_MAN_RST 17'h00000
`define SDC_AVG_MSB 3
`define SDC_AVG_LSB 2
`define SDC_LEN_MSB 1
`define SDC_LEN_LSB 0
`define SDC_DONE_BIT 17
`define SDC_INV_BIT 16
`define SDC_RESULT_W 17

// ==========================================================
// Timing
`define SDC_STEP_UNIT 1024
`define SDC_CAL_STEPS 19
`define SDC_SEARCH_LAST 5'd17
`define SDC_PERIOD_W 15
`define SDC_PERIOD_MAX0 15'd85
`define SDC_PERIOD_MAX1 15'd1100
`define SDC_PERIOD_MAX2 15'd5200
`define SDC_PERIOD_MAX3 15'd21580

`endif

// *** rtl/sdc_pkg.sv ***
// Types of the SYSREF delay calibration register bank
package sdc_pkg;

  // ==========================================================
  // Calibration sequencer states, one-hot
  typedef enum logic [4:0] {
    SDC_IDLE   = 5'b00001,
    SDC_PERIOD = 5'b00010,
    SDC_SEARCH = 5'b00100,
    SDC_DONE   = 5'b01000,
    SDC_FAIL   = 5'b10000
  } sdc_state_e;

  typedef logic [16:0] sdc_delay_t;

endpackage

// *** rtl/sdc_meas_if.sv ***
// Interface between the sequencer and its measurement helpers
`timescale 1ns/1ps
`default_nettype none
interface sdc_meas_if;
  logic clear;
  logic [1:0] avg_sel;
  logic [1:0] len_sel;
  logic majority;
  logic pulse_seen;
  logic too_long;

  modport ctrl (output clear, avg_sel, len_sel, input majority, pulse_seen, too_long);
  modport vote (input clear, avg_sel, len_sel, output majority);
  modport meter (input clear, len_sel, output pulse_seen, too_long);
endinterface
`default_nettype wire

// *** rtl/sdc_phase_vote.sv ***
// Accumulates phase-detector votes over SYSREF-triggered windows
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_phase_vote (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link side
  input wire logic sysref,
  input wire logic phase_early,
  // Sequencer
  sdc_meas_if.vote meas
);

  logic [8:0] taken_r, taken_nxt;
  logic [8:0] win_r, win_nxt;
  logic in_win_r, in_win_nxt;
  logic [16:0] early_r, early_nxt;
  logic [16:0] late_r, late_nxt;
  logic [8:0] acc_limit;
  logic [8:0] win_len;

  // 4, 16, 64 or 256 accumulations and cycles per accumulation
  assign acc_limit = 9'h001 << {meas.avg_sel, 1'b0} + 9'h002;
  assign win_len = 9'h001 << {meas.len_sel, 1'b0} + 9'h002;
  assign meas.majority = early_r > late_r;

  always_comb begin
    taken_nxt = taken_r;
    win_nxt = win_r;
    in_win_nxt = in_win_r;
    early_nxt = early_r;
    late_nxt = late_r;
    if (meas.clear) begin
      taken_nxt = 9'h000;
      win_nxt = 9'h000;
      in_win_nxt = 1'b0;
      early_nxt = 17'h00000;
      late_nxt = 17'h00000;
    end else if (in_win_r) begin
      if (phase_early) begin
        early_nxt = early_r + 17'h00001;
      end else begin
        late_nxt = late_r + 17'h00001;
      end
      win_nxt = win_r + 9'h001;
      if (win_r == win_len - 9'h001) begin
        in_win_nxt = 1'b0;
      end
    end else if (sysref && taken_r < acc_limit) begin
      in_win_nxt = 1'b1;
      win_nxt = 9'h000;
      taken_nxt = taken_r + 9'h001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      taken_r <= 9'h000;
      win_r <= 9'h000;
      in_win_r <= 1'b0;
      early_r <= 17'h00000;
      late_r <= 17'h00000;
    end else begin
      taken_r <= taken_nxt;
      win_r <= win_nxt;
      in_win_r <= in_win_nxt;
      early_r <= early_nxt;
      late_r <= late_nxt;
    end
  end

endmodule // sdc_phase_vote
`default_nettype wire

// *** rtl/sdc_period_meter.sv ***
// Measures the SYSREF period against the supported maximum
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_period_meter (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link side
  input wire logic sysref,
  // Sequencer
  sdc_meas_if.meter meas
);

  logic [`SDC_PERIOD_W-1:0] cnt_r, cnt_nxt;
  logic seen_r, seen_nxt;
  logic long_r, long_nxt;
  logic [`SDC_PERIOD_W-1:0] limit;

  always_comb begin
    case (meas.len_sel)
      2'd0: limit = `SDC_PERIOD_MAX0;
      2'd1: limit = `SDC_PERIOD_MAX1;
      2'd2: limit = `SDC_PERIOD_MAX2;
      default: limit = `SDC_PERIOD_MAX3;
    endcase
  end

  assign meas.pulse_seen = seen_r;
  assign meas.too_long = long_r;

  always_comb begin
    cnt_nxt = cnt_r;
    seen_nxt = seen_r;
    long_nxt = long_r;
    if (meas.clear) begin
      cnt_nxt = '0;
      seen_nxt = 1'b0;
      long_nxt = 1'b0;
    end else begin
      // Counter holds cycles since the last pulse, so it equals the period at the next one
      if (sysref) begin
        cnt_nxt = {{(`SDC_PERIOD_W-1){1'b0}}, 1'b1};
        seen_nxt = 1'b1;
      end else if (cnt_r != '1) begin
        cnt_nxt = cnt_r + {{(`SDC_PERIOD_W-1){1'b0}}, 1'b1};
      end
      if (seen_r && cnt_r > limit) begin
        long_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      seen_r <= 1'b0;
      long_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      seen_r <= seen_nxt;
      long_r <= long_nxt;
    end
  end

endmodule // sdc_period_meter
`default_nettype wire

// *** rtl/sdc_regs.sv ***
// SYSREF delay calibration: registers, sequencer and delay selection
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"

// Notes on behaviour
// - Averaging code bits 3-2, reset 1, picks 4/16/64/256 accumulations per measurement.
// - Length code bits 1-0, reset 1, 4/16/64/256 cycles; periods 85/1100/5200/21580.
// - Calibration fails when the SYSREF period exceeds the supported maximum.
// - Larger codes give longer calibration and steadier results.
// - Completion bit 17 reads one only while enabled and finished.
// - Bits 16-0 hold the calibrated delay, valid only when complete.
// - Result bit 16 is inversion, 15:8 coarse, 7:0 fine.
// - Status is a read-only 24-bit register, zero after reset.
// - Manual delay is 17 bits over three bytes, resets to zero.
// - Rising enable starts calibration; host configures first, ADC calibration idle.
// - Calibration ends within 256*19*4*(avg+len+2) sample-clock cycles.
// - Enabled uses calibrated delay, manual register ignored; disabled uses manual.
// - Manual bit 16 inverts clock, 15:8 coarse, 7:0 fine.
module sdc_regs #(
  parameter int STEP_UNIT_CYCLES = `SDC_STEP_UNIT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [`SDC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Calibration control
  input wire logic delay_cal_enable,
  input wire logic sysref,
  input wire logic phase_early,
  output logic delay_cal_complete,
  output logic cal_failed,
  // Delay line
  output logic [16:0] aperture_delay
);

  // ==========================================================
  // Configuration and manual delay registers
  logic [1:0] averaging_select_r, averaging_select_nxt;
  logic [1:0] accumulation_length_select_r, accumulation_length_select_nxt;
  sdc_pkg::sdc_delay_t manual_delay_setting_r, manual_delay_setting_nxt;

  always_comb begin
    averaging_select_nxt = averaging_select_r;
    accumulation_length_select_nxt = accumulation_length_select_r;
    manual_delay_setting_nxt = manual_delay_setting_r;
    if (reg_wr) begin
      case (reg_addr)
        `SDC_ADDR_CFG: begin
          averaging_select_nxt = reg_wdata[`SDC_AVG_MSB:`SDC_AVG_LSB];
          accumulation_length_select_nxt = reg_wdata[`SDC_LEN_MSB:`SDC_LEN_LSB];
        end
        `SDC_ADDR_MAN0: manual_delay_setting_nxt[7:0] = reg_wdata;
        `SDC_ADDR_MAN1: manual_delay_setting_nxt[15:8] = reg_wdata;
        `SDC_ADDR_MAN2: manual_delay_setting_nxt[16] = reg_wdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      averaging_select_r <= 2'h1;
      accumulation_length_select_r <= 2'h1;
      manual_delay_setting_r <= `SDC_MAN_RST;
    end else begin
      averaging_select_r <= averaging_select_nxt;
      accumulation_length_select_r <= accumulation_length_select_nxt;
      manual_delay_setting_r <= manual_delay_setting_nxt;
    end
  end

  // ==========================================================
  // Measurement helpers
  sdc_meas_if meas ();

  assign meas.avg_sel = averaging_select_r;
  assign meas.len_sel = accumulation_length_select_r;

  sdc_phase_vote u_vote (
    .clock(clock),
    .rst(rst),
    .sysref(sysref),
    .phase_early(phase_early),
    .meas(meas)
  );

  sdc_period_meter u_meter (
    .clock(clock),
    .rst(rst),
    .sysref(sysref),
    .meas(meas)
  );

  // ==========================================================
  // Calibration sequencer
  sdc_pkg::sdc_state_e state_r, state_nxt;
  logic enable_d_r, enable_d_nxt;
  logic [19:0] step_cnt_r, step_cnt_nxt;
  logic [4:0] step_idx_r, step_idx_nxt;
  sdc_pkg::sdc_delay_t trial_r, trial_nxt;
  sdc_pkg::sdc_delay_t result_r, result_nxt;
  logic done_r, done_nxt;
  logic fail_r, fail_nxt;
  logic start;
  logic step_end;
  logic [19:0] step_len;
  logic [3:0] code_sum;
  logic [4:0] bit_pos;

  assign start = delay_cal_enable && !enable_d_r;
  // Each of the 19 steps lasts unit*(avg+len+2) cycles, bounding the whole run
  assign code_sum = {2'b00, averaging_select_r} + {2'b00, accumulation_length_select_r}
    + 4'h2;
  assign step_len = 20'(STEP_UNIT_CYCLES) * {16'h0000, code_sum};
  assign step_end = step_cnt_r == step_len - 20'h00001;
  assign bit_pos = 5'd16 - step_idx_r;
  assign meas.clear = start || step_end;

  always_comb begin
    state_nxt = state_r;
    enable_d_nxt = delay_cal_enable;
    step_cnt_nxt = step_cnt_r;
    step_idx_nxt = step_idx_r;
    trial_nxt = trial_r;
    result_nxt = result_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    if (!delay_cal_enable) begin
      state_nxt = sdc_pkg::SDC_IDLE;
      done_nxt = 1'b0;
      fail_nxt = 1'b0;
    end else if (start) begin
      state_nxt = sdc_pkg::SDC_PERIOD;
      step_cnt_nxt = 20'h00000;
      step_idx_nxt = 5'd0;
      trial_nxt = '0;
      done_nxt = 1'b0;
      fail_nxt = 1'b0;
    end else begin
      case (state_r)
        sdc_pkg::SDC_IDLE: ;
        sdc_pkg::SDC_PERIOD: begin
          step_cnt_nxt = step_end ? 20'h00000 : step_cnt_r + 20'h00001;
          if (meas.too_long) begin
            state_nxt = sdc_pkg::SDC_FAIL;
          end else if (step_end) begin
            state_nxt = meas.pulse_seen ? sdc_pkg::SDC_SEARCH : sdc_pkg::SDC_FAIL;
          end
        end
        sdc_pkg::SDC_SEARCH: begin
          step_cnt_nxt = step_end ? 20'h00000 : step_cnt_r + 20'h00001;
          if (meas.too_long) begin
            state_nxt = sdc_pkg::SDC_FAIL;
          end else if (step_end) begin
            step_idx_nxt = step_idx_r + 5'd1;
            if (step_idx_r == 5'd0) begin
              // First step decides clock inversion, then the coarse MSB is tried
              trial_nxt[`SDC_INV_BIT] = meas.majority;
              trial_nxt[15] = 1'b1;
            end else if (step_idx_r < `SDC_SEARCH_LAST) begin
              // Binary search: keep the tried bit only while the clock still leads
              trial_nxt[bit_pos[3:0]] = meas.majority;
              if (bit_pos != 5'd0) begin
                trial_nxt[bit_pos[3:0] - 4'd1] = 1'b1;
              end
            end else begin
              state_nxt = sdc_pkg::SDC_DONE;
              result_nxt = trial_r;
              done_nxt = 1'b1;
            end
          end
        end
        sdc_pkg::SDC_DONE: ;
        sdc_pkg::SDC_FAIL: fail_nxt = 1'b1;
        default: state_nxt = sdc_pkg::SDC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= sdc_pkg::SDC_IDLE;
      enable_d_r <= 1'b0;
      step_cnt_r <= 20'h00000;
      step_idx_r <= 5'd0;
      trial_r <= '0;
      result_r <= '0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      enable_d_r <= enable_d_nxt;
      step_cnt_r <= step_cnt_nxt;
      step_idx_r <= step_idx_nxt;
      trial_r <= trial_nxt;
      result_r <= result_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign delay_cal_complete = done_r && delay_cal_enable;
  assign cal_failed = fail_r;

  // ==========================================================
  // Applied aperture delay
  sdc_pkg::sdc_delay_t delay_r, delay_nxt;

  always_comb begin
    if (!delay_cal_enable) begin
      delay_nxt = manual_delay_setting_r;
    end else if (done_r) begin
      delay_nxt = result_r;
    end else begin
      delay_nxt = trial_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      delay_r <= `SDC_MAN_RST;
    end else begin
      delay_r <= delay_nxt;
    end
  end

  assign aperture_delay = delay_r;

  // ==========================================================
  // Register read-back
  logic [23:0] status_word;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  // Status is read only; writes to its bytes are dropped
  assign status_word = {6'h00, delay_cal_complete, result_r};

  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        `SDC_ADDR_CFG: rdata_nxt = {4'h0, averaging_select_r, accumulation_length_select_r};
        `SDC_ADDR_STAT0: rdata_nxt = status_word[7:0];
        `SDC_ADDR_STAT1: rdata_nxt = status_word[15:8];
        `SDC_ADDR_STAT2: rdata_nxt = status_word[23:16];
        `SDC_ADDR_MAN0: rdata_nxt = manual_delay_setting_r[7:0];
        `SDC_ADDR_MAN1: rdata_nxt = manual_delay_setting_r[15:8];
        `SDC_ADDR_MAN2: rdata_nxt = {7'h00, manual_delay_setting_r[16]};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

endmodule // sdc_regs
`default_nettype wire

// *** sim/sdc_regs_monitor.sv ***
// Concurrent checks on the ports of the delay calibration register bank
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module sdc_regs_monitor #(
  parameter int STEP_UNIT_CYCLES = `SDC_STEP_UNIT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [`SDC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Calibration
  input wire logic delay_cal_enable,
  input wire logic sysref,
  input wire logic phase_early,
  input wire logic delay_cal_complete,
  input wire logic cal_failed,
  input wire logic [16:0] aperture_delay
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================
  // Cycles spent calibrating without an outcome
  localparam int CAL_MAX = STEP_UNIT_CYCLES * `SDC_CAL_STEPS * 8 + 8;
  logic [31:0] wait_r;
  logic [31:0] wait_nxt;
  always_comb begin
    wait_nxt = 32'h00000000;
    if (delay_cal_enable && !delay_cal_complete && !cal_failed) begin
      wait_nxt = wait_r + 32'h00000001;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_r <= 32'h00000000;
    end else begin
      wait_r <= wait_nxt;
    end
  end

  // ==========================================================
  // Properties
  property p_rvalid;
    reg_rd |=> reg_rvalid;
  endproperty
  property p_cfg_upper;
    reg_rd && reg_addr == `SDC_ADDR_CFG |=> reg_rdata[7:4] == 4'h0;
  endproperty
  property p_man_upper;
    reg_rd && reg_addr == `SDC_ADDR_MAN2 |=> reg_rdata[7:1] == 7'h00;
  endproperty
  property p_status_done;
    reg_rd && reg_addr == `SDC_ADDR_STAT2 |=>
      reg_rdata[7:1] == {6'h00, $past(delay_cal_complete)};
  endproperty
  property p_complete_en;
    delay_cal_complete |-> delay_cal_enable;
  endproperty
  property p_fresh_start;
    $rose(delay_cal_enable) |-> !delay_cal_complete [*8];
  endproperty
  property p_fail_excl;
    cal_failed |-> !delay_cal_complete;
  endproperty
  property p_manual_apply;
    (reg_wr && reg_addr == `SDC_ADDR_MAN0 && !delay_cal_enable) ##1
      (!delay_cal_enable && !reg_wr) |=> aperture_delay[7:0] == $past(reg_wdata, 2);
  endproperty
  property p_cal_bound;
    wait_r <= CAL_MAX;
  endproperty

  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  a_cfg_upper: assert property (p_cfg_upper) else $error("config upper bits set");
  a_man_upper: assert property (p_man_upper) else $error("manual upper bits set");
  a_status_done: assert property (p_status_done) else $error("status done bit wrong");
  a_complete_en: assert property (p_complete_en) else $error("complete without enable");
  a_fresh_start: assert property (p_fresh_start) else $error("stale completion");
  a_fail_excl: assert property (p_fail_excl) else $error("failed and complete");
  a_manual_apply: assert property (p_manual_apply) else $error("manual delay unused");
  a_cal_bound: assert property (p_cal_bound) else $error("calibration too long");

  c_done: cover property ($rose(delay_cal_complete));
  c_fail: cover property ($rose(cal_failed));
  c_read: cover property (reg_rvalid);
  c_write: cover property (reg_wr && reg_addr == `SDC_ADDR_MAN0);
endmodule // sdc_regs_monitor
`default_nettype wire

// *** sim/tb_sdc_regs.sv ***
// Self-checking bench for the delay calibration register bank
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.svh"
module tb_sdc_regs;
  localparam int UNIT = 8;
  logic clock;
  logic rst;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic delay_cal_enable;
  logic sysref;
  logic phase_early;
  logic delay_cal_complete;
  logic cal_failed;
  logic [16:0] aperture_delay;
  int err_total;
  int n_compared;
  int sr_per;
  int t0;
  int t1;
  logic [7:0] b;
  logic [23:0] s;
  logic [23:0] s2;

  sdc_regs #(.STEP_UNIT_CYCLES(UNIT)) DUT (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .delay_cal_enable(delay_cal_enable), .sysref(sysref), .phase_early(phase_early),
    .delay_cal_complete(delay_cal_complete), .cal_failed(cal_failed),
    .aperture_delay(aperture_delay)
  );

  // ==========================================================
  // Clock, SYSREF pulses and watchdog
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    sysref = 1'b0;
    // Shorter than the 16-cycle step of codes 0 at UNIT 8, so every step sees a pulse
    sr_per = 12;
    forever begin
      repeat (sr_per - 1) @(posedge clock);
      #1 sysref = 1'b1;
      @(posedge clock);
      #1 sysref = 1'b0;
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end

  // ==========================================================
  // Access and compare tasks
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
    chk("reg_rvalid", 24'h000001, {23'h0, reg_rvalid});
    @(posedge clock);
    #1;
  endtask
  task automatic rd24(input logic [11:0] a, output logic [23:0] v);
    for (int i = 0; i < 3; i++) begin
      rd(a + 12'(i), v[8*i +: 8]);
    end
  endtask
  task automatic cal(input logic [7:0] cfg, output int cyc);
    wr(`SDC_ADDR_CFG, cfg);
    delay_cal_enable = 1'b1;
    cyc = 0;
    while (delay_cal_complete !== 1'b1 && cal_failed !== 1'b1 && cyc < 3000) begin
      @(posedge clock);
      #1 cyc++;
    end
  endtask
  task automatic stop_cal();
    delay_cal_enable = 1'b0;
    #1 chk("delay_cal_complete", 24'h0, {23'h0, delay_cal_complete});
    @(posedge clock);
    #1;
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    delay_cal_enable = 1'b0;
    phase_early = 1'b1;
    repeat (5) @(posedge clock);
    #1 rst = 1'b0;
    rd(`SDC_ADDR_CFG, b);
    chk("config reset", 24'h05, {16'h0, b});
    rd24(`SDC_ADDR_MAN0, s);
    chk("manual reset", 24'h000000, s);
    rd(12'h2b8, b);
    chk("unmapped read", 24'h00, {16'h0, b});
    rd24(`SDC_ADDR_STAT0, s);
    wr(`SDC_ADDR_STAT0, 8'h5a);
    wr(`SDC_ADDR_STAT2, 8'hff);
    rd24(`SDC_ADDR_STAT0, s2);
    chk("status after write", s, s2);
    for (int i = 0; i < 4; i++) begin
      wr(`SDC_ADDR_CFG, {4'hf, 2'(i), ~2'(i)});
      rd(`SDC_ADDR_CFG, b);
      chk("config readback", {16'h0, 4'h0, 2'(i), ~2'(i)}, {16'h0, b});
    end
    wr(`SDC_ADDR_MAN0, 8'h34);
    wr(`SDC_ADDR_MAN1, 8'h12);
    wr(`SDC_ADDR_MAN2, 8'hff);
    rd24(`SDC_ADDR_MAN0, s);
    chk("manual readback", 24'h011234, s);
    chk("aperture_delay manual", 24'h011234, {7'h0, aperture_delay});
    // Short codes with a fast SYSREF
    cal(8'h00, t0);
    chk("cal time codes 0", 24'h1, {23'h0, t0 <= UNIT * 19 * 2 + 4});
    rd24(`SDC_ADDR_STAT0, s);
    chk("status done", 24'h1, {23'h0, s[`SDC_DONE_BIT]});
    chk("aperture_delay result", {7'h0, s[16:0]}, {7'h0, aperture_delay});
    wr(`SDC_ADDR_MAN0, 8'h77);
    chk("aperture_delay ignores manual", {7'h0, s[16:0]}, {7'h0, aperture_delay});
    stop_cal();
    rd(`SDC_ADDR_STAT2, b);
    chk("status done cleared", 24'h0, {23'h0, b[1]});
    // Host copies the result into the manual register
    for (int i = 0; i < 3; i++) begin
      wr(`SDC_ADDR_MAN0 + 12'(i), s[8*i +: 8]);
    end
    rd24(`SDC_ADDR_MAN0, s2);
    chk("manual copy", {7'h0, s[16:0]}, s2);
    chk("aperture_delay copy", {7'h0, s[16:0]}, {7'h0, aperture_delay});
    // Larger codes take longer
    phase_early = 1'b0;
    cal(8'h0a, t1);
    chk("cal time codes 2", 24'h1, {23'h0, t1 <= UNIT * 19 * 6 + 4});
    chk("longer with larger codes", 24'h1, {23'h0, t1 > t0});
    chk("complete codes 2", 24'h1, {23'h0, delay_cal_complete});
    rd24(`SDC_ADDR_STAT0, s);
    chk("status late clock", 24'h020000, s);
    stop_cal();
    // SYSREF period far beyond the shortest accumulation length
    sr_per = 4000;
    repeat (16) @(posedge clock);
    #1;
    cal(8'h00, t0);
    chk("cal_failed", 24'h1, {23'h0, cal_failed});
    chk("complete on failure", 24'h0, {23'h0, delay_cal_complete});
    stop_cal();
    tally_and_finish();
  end
endmodule // tb_sdc_regs

bind sdc_regs sdc_regs_monitor #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) u_mon (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .delay_cal_enable(delay_cal_enable), .sysref(sysref), .phase_early(phase_early),
  .delay_cal_complete(delay_cal_complete), .cal_failed(cal_failed),
  .aperture_delay(aperture_delay)
);
`default_nettype wire
